// >>> rtl/rcf_stage.sv
// Frequency slope protection stage with AXI4-Lite register access.
// Assumes a one-cycle protection tick pulse and a signed averaged slope input.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`include "rcf_params.svh"

module rcf_stage #(
  parameter int SW = 16,
  parameter int FLOOR_TICKS = `RCF_SLOW_FLOOR_TICKS
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Measurement path
  input wire logic tick_in,
  input wire logic signed [SW-1:0] slope_in,
  // Setting group selectors
  input wire logic [1:0] grp_di_in,
  input wire logic [1:0] grp_vi_in,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Stage outputs
  output logic start_out,
  output logic trip_out,
  output logic start_on_evt_out,
  output logic start_off_evt_out,
  output logic trip_on_evt_out,
  output logic trip_off_evt_out
);

  localparam logic [7:0] PICK_T = 8'(`RCF_PICKUP_TICKS);
  localparam logic [7:0] START_T = 8'(`RCF_START_TICKS);
  localparam logic [7:0] STABLE_T = 8'(`RCF_STABLE_TICKS);
  localparam logic [10:0] FLOOR_T = 11'(FLOOR_TICKS);
  localparam logic [1:0] OKAY = 2'h0;
  localparam logic [1:0] SLVERR = 2'h2;
  localparam logic [1:0] DECERR = 2'h3;

  rcf_pkg::rcf_state_t state_r, state_nxt;
  logic [7:0] ctrl_r;
  logic [1:0] act_grp_r;
  logic [1:0] scan_fld_r, scan_prev_r;
  logic [15:0] set_slope_r, set_opdly_r, set_mindly_r;
  logic [15:0] mem_a_data, mem_b_data;
  logic mem_wr_en;
  logic [15:0] abs_slope, meas_r;
  logic above;
  logic [7:0] hi_r, hi_nxt, lo_r, lo_nxt, sdly_r, sdly_nxt;
  logic [10:0] n_r, n_nxt, n_inc, minimum_delay_setting_eff;
  logic [31:0] sum_r, sum_nxt, sum_new, prod;
  logic [15:0] fmax_r, fmax_nxt, fault_max_r;
  logic start_r, start_nxt, trip_r, trip_nxt;
  logic pickup_now, release_now;
  logic [15:0] pend_r;
  logic [9:0] frac_r;
  logic [7:0] pct_r, elapsed_delay_percent_r;
  logic [31:0] start_count_r, trip_count_r;
  logic aw_rdy_r, w_rdy_r, bvalid_r, ar_rdy_r, rpend_r, rvalid_r;
  logic [7:0] aw_addr_r, ar_addr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, set_hit, set_ok;
  logic [15:0] wval;

  ////////////////////////////////////////////////////////////////////////////////
  // Setting store and active group scan
  rcf_setmem #(
    .W(16),
    .GRPS(4)
  ) u_setmem (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .wr_en_in(mem_wr_en),
    .wr_addr_in(aw_addr_r[5:2]),
    .wr_data_in(wval),
    .rd_a_addr_in({act_grp_r, scan_fld_r}),
    .rd_a_data_out(mem_a_data),
    .rd_b_addr_in(s_axi_araddr_in[5:2]),
    .rd_b_data_out(mem_b_data)
  );

  // Active group from the selected source
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      act_grp_r <= 2'h0;
    end else begin
      case (rcf_pkg::rcf_src_t'(ctrl_r[`RCF_CTRL_SRC_LSB +: 2]))
        rcf_pkg::RCF_SRC_DI: act_grp_r <= grp_di_in;
        rcf_pkg::RCF_SRC_VI: act_grp_r <= grp_vi_in;
        default: act_grp_r <= ctrl_r[`RCF_CTRL_GRP_LSB +: 2];
      endcase
    end
  end

  // Shadow copy of the active group's three settings, refreshed round-robin
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      scan_fld_r <= `RCF_FLD_SLOPE;
      scan_prev_r <= `RCF_FLD_SLOPE;
      set_slope_r <= `RCF_SLOPE_RST;
      set_opdly_r <= `RCF_DLY_RST;
      set_mindly_r <= `RCF_DLY_RST;
    end else begin
      scan_fld_r <= (scan_fld_r == `RCF_FLD_MINDLY) ? `RCF_FLD_SLOPE : scan_fld_r + 2'h1;
      scan_prev_r <= scan_fld_r;
      case (scan_prev_r)
        `RCF_FLD_SLOPE: set_slope_r <= mem_a_data;
        `RCF_FLD_OPDLY: set_opdly_r <= mem_a_data;
        default: set_mindly_r <= mem_a_data;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slope magnitude and derived trip terms
  assign abs_slope = slope_in[SW-1] ? 16'(-slope_in) : 16'(slope_in);
  assign above = abs_slope > set_slope_r;
  assign n_inc = (n_r == 11'h7FF) ? n_r : n_r + 11'h001;
  assign sum_new = sum_r + {16'h0000, abs_slope};
  assign prod = 32'(set_slope_r[9:0]) * 32'(set_opdly_r[9:0]);

  // Minimum delay, raised for very sensitive slope settings
  always_comb begin
    minimum_delay_setting_eff = set_mindly_r[10:0];
    if ((set_slope_r < `RCF_SLOW_SLOPE) && (minimum_delay_setting_eff < FLOOR_T)) begin
      minimum_delay_setting_eff = FLOOR_T;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stage sequence, evaluated once per protection tick
  always_comb begin
    state_nxt = state_r;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    sdly_nxt = sdly_r;
    n_nxt = n_r;
    sum_nxt = sum_r;
    fmax_nxt = fmax_r;
    start_nxt = start_r;
    trip_nxt = trip_r;
    pickup_now = 1'b0;
    release_now = 1'b0;
    if (tick_in) begin
      case (state_r)
        rcf_pkg::RCF_IDLE: begin
          if (!above) begin
            hi_nxt = 8'h00;
          end else if (hi_r == PICK_T - 8'h01) begin
            state_nxt = rcf_pkg::RCF_PICKED;
            pickup_now = 1'b1;
            hi_nxt = 8'h00;
            lo_nxt = 8'h00;
            sdly_nxt = 8'h00;
            n_nxt = 11'h000;
            sum_nxt = 32'h00000000;
            fmax_nxt = abs_slope;
          end else begin
            hi_nxt = hi_r + 8'h01;
          end
        end
        rcf_pkg::RCF_PICKED, rcf_pkg::RCF_TRIPPED: begin
          n_nxt = n_inc;
          sum_nxt = sum_new;
          if (abs_slope > fmax_r) begin
            fmax_nxt = abs_slope;
          end
          lo_nxt = above ? 8'h00 : ((lo_r == 8'hFF) ? lo_r : lo_r + 8'h01);
          if (!start_r) begin
            sdly_nxt = sdly_r + 8'h01;
            if (sdly_r == START_T - 8'h01) begin
              start_nxt = 1'b1;
            end
          end
          // Trip: inverse once sum reaches s_set*t_set, at the delay itself only once sum exceeds it
          if ((state_r == rcf_pkg::RCF_PICKED) && (n_inc >= minimum_delay_setting_eff) &&
              (n_inc <= set_opdly_r[10:0])) begin
            if ((n_inc == set_opdly_r[10:0]) ? (sum_new > prod) : (sum_new >= prod)) begin
              state_nxt = rcf_pkg::RCF_TRIPPED;
              trip_nxt = 1'b1;
            end
          end
          // Release only after a stable spell and an elapsed delay or trip
          if ((lo_nxt >= STABLE_T) &&
              ((state_r == rcf_pkg::RCF_TRIPPED) || (n_inc >= set_opdly_r[10:0]))) begin
            state_nxt = rcf_pkg::RCF_IDLE;
            release_now = 1'b1;
            start_nxt = 1'b0;
            trip_nxt = 1'b0;
          end
        end
        default: state_nxt = rcf_pkg::RCF_IDLE;
      endcase
    end
  end

  // Sequence registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_r <= rcf_pkg::RCF_IDLE;
      hi_r <= 8'h00;
      lo_r <= 8'h00;
      sdly_r <= 8'h00;
      n_r <= 11'h000;
      sum_r <= 32'h00000000;
      fmax_r <= 16'h0000;
      start_r <= 1'b0;
      trip_r <= 1'b0;
      meas_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      sdly_r <= sdly_nxt;
      n_r <= n_nxt;
      sum_r <= sum_nxt;
      fmax_r <= fmax_nxt;
      start_r <= start_nxt;
      trip_r <= trip_nxt;
      if (tick_in) begin
        meas_r <= abs_slope;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Elapsed percent: 100 units per tick, drained one per clock against t_set
  always_ff @(posedge mclk_in) begin
    if (srst_in || pickup_now) begin
      pend_r <= 16'h0000;
      frac_r <= 10'h000;
      pct_r <= 8'h00;
    end else begin
      pend_r <= pend_r + ((tick_in && (state_r != rcf_pkg::RCF_IDLE)) ? 16'h0064 : 16'h0000)
                - ((pend_r != 16'h0000) ? 16'h0001 : 16'h0000);
      if (pend_r != 16'h0000) begin
        if (frac_r + 10'h001 >= set_opdly_r[9:0]) begin
          frac_r <= 10'h000;
          pct_r <= (pct_r == 8'hFF) ? pct_r : pct_r + 8'h01;
        end else begin
          frac_r <= frac_r + 10'h001;
        end
      end
    end
  end

  // Fault records taken at release
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      fault_max_r <= 16'h0000;
      elapsed_delay_percent_r <= 8'h00;
    end else if (release_now) begin
      fault_max_r <= fmax_nxt;
      elapsed_delay_percent_r <= trip_r ? `RCF_PCT_FULL : pct_r;
    end
  end

  // Start and trip counters; a clear in the same cycle as an increment leaves a count of 1
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      start_count_r <= 32'h00000000;
      trip_count_r <= 32'h00000000;
    end else begin
      if (start_nxt && !start_r) begin
        start_count_r <= (wr_fire && (aw_addr_r == `RCF_ADDR_START_COUNT)) ?
                         32'h00000001 : start_count_r + 32'h00000001;
      end else if (wr_fire && (aw_addr_r == `RCF_ADDR_START_COUNT)) begin
        start_count_r <= 32'h00000000;
      end
      if (trip_nxt && !trip_r) begin
        trip_count_r <= (wr_fire && (aw_addr_r == `RCF_ADDR_TRIP_COUNT)) ?
                        32'h00000001 : trip_count_r + 32'h00000001;
      end else if (wr_fire && (aw_addr_r == `RCF_ADDR_TRIP_COUNT)) begin
        trip_count_r <= 32'h00000000;
      end
    end
  end

  // Gated event pulses
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      start_on_evt_out <= 1'b0;
      start_off_evt_out <= 1'b0;
      trip_on_evt_out <= 1'b0;
      trip_off_evt_out <= 1'b0;
    end else begin
      start_on_evt_out <= ctrl_r[`RCF_CTRL_SON_BIT] && start_nxt && !start_r;
      start_off_evt_out <= ctrl_r[`RCF_CTRL_SOFF_BIT] && !start_nxt && start_r;
      trip_on_evt_out <= ctrl_r[`RCF_CTRL_TON_BIT] && trip_nxt && !trip_r;
      trip_off_evt_out <= ctrl_r[`RCF_CTRL_TOFF_BIT] && !trip_nxt && trip_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write decode and range checks
  assign wr_fire = !aw_rdy_r && !w_rdy_r && !bvalid_r;
  assign wval = wdata_r[15:0];
  assign set_hit = (aw_addr_r[7:6] == `RCF_SET_REGION) && (aw_addr_r[3:2] != 2'h3);
  always_comb begin
    if (wstrb_r[1:0] != 2'h3) begin
      set_ok = 1'b0;
    end else if (aw_addr_r[3:2] == `RCF_FLD_SLOPE) begin
      set_ok = (wval >= `RCF_SLOPE_MIN) && (wval <= `RCF_SLOPE_MAX);
    end else begin
      set_ok = (wval >= `RCF_DLY_MIN) && (wval <= `RCF_DLY_MAX);
    end
  end
  assign mem_wr_en = wr_fire && set_hit && set_ok && (aw_addr_r[1:0] == 2'h0);

  // Write channels, one write under way at a time
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      aw_rdy_r <= 1'b1;
      w_rdy_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= OKAY;
      aw_addr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      ctrl_r <= `RCF_CTRL_RST;
    end else begin
      if (aw_rdy_r && s_axi_awvalid_in) begin
        aw_rdy_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (w_rdy_r && s_axi_wvalid_in) begin
        w_rdy_r <= 1'b0;
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        if (set_hit) begin
          bresp_r <= mem_wr_en ? OKAY : SLVERR;
        end else begin
          case (aw_addr_r)
            `RCF_ADDR_CTRL: begin
              bresp_r <= OKAY;
              if (wstrb_r[0]) begin
                ctrl_r <= wdata_r[7:0];
              end
            end
            `RCF_ADDR_START_COUNT, `RCF_ADDR_TRIP_COUNT: bresp_r <= OKAY;
            `RCF_ADDR_STATUS, `RCF_ADDR_FAULT_MAX, `RCF_ADDR_ELAPSED_DELAY_PERCENT,
            `RCF_ADDR_SLOPE_MEAS: bresp_r <= SLVERR;
            default: bresp_r <= DECERR;
          endcase
        end
      end
      if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: address taken, data and rvalid one cycle later
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ar_rdy_r <= 1'b1;
      rpend_r <= 1'b0;
      rvalid_r <= 1'b0;
      ar_addr_r <= 8'h00;
      rdata_r <= 32'h00000000;
      rresp_r <= OKAY;
    end else begin
      if (ar_rdy_r && s_axi_arvalid_in) begin
        ar_rdy_r <= 1'b0;
        rpend_r <= 1'b1;
        ar_addr_r <= s_axi_araddr_in;
      end
      if (rpend_r) begin
        rpend_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= OKAY;
        if ((ar_addr_r[7:6] == `RCF_SET_REGION) && (ar_addr_r[3:2] != 2'h3)) begin
          rdata_r <= {16'h0000, mem_b_data};
        end else begin
          case (ar_addr_r)
            `RCF_ADDR_CTRL: rdata_r <= {24'h000000, ctrl_r};
            `RCF_ADDR_STATUS: rdata_r <= {26'h0000000, act_grp_r, 1'b0,
                                          state_r != rcf_pkg::RCF_IDLE, trip_r, start_r};
            `RCF_ADDR_START_COUNT: rdata_r <= start_count_r;
            `RCF_ADDR_TRIP_COUNT: rdata_r <= trip_count_r;
            `RCF_ADDR_FAULT_MAX: rdata_r <= {16'h0000, fault_max_r};
            `RCF_ADDR_ELAPSED_DELAY_PERCENT: rdata_r <= {24'h000000, elapsed_delay_percent_r};
            `RCF_ADDR_SLOPE_MEAS: rdata_r <= {16'h0000, meas_r};
            default: begin
              rdata_r <= 32'h00000000;
              rresp_r <= DECERR;
            end
          endcase
        end
      end
      if (rvalid_r && s_axi_rready_in) begin
        rvalid_r <= 1'b0;
        ar_rdy_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output drive
  assign s_axi_awready_out = aw_rdy_r;
  assign s_axi_wready_out = w_rdy_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = ar_rdy_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign start_out = start_r;
  assign trip_out = trip_r;

endmodule

// >>> rtl/rcf_params.svh
// Constants of the frequency slope protection stage: offsets, fields, resets, timing.
// Assumes a byte-addressed AXI4-Lite map and a protection tick of fixed period.
`ifndef RCF_PARAMS_SVH
`define RCF_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define RCF_ADDR_CTRL 8'h00
`define RCF_ADDR_STATUS 8'h04
`define RCF_ADDR_START_COUNT 8'h08
`define RCF_ADDR_TRIP_COUNT 8'h0C
`define RCF_ADDR_FAULT_MAX 8'h10
`define RCF_ADDR_ELAPSED_DELAY_PERCENT 8'h14
`define RCF_ADDR_SLOPE_MEAS 8'h18
// Setting window: base, group stride 0x10, field stride 0x04
`define RCF_SET_REGION 2'h1
`define RCF_FLD_SLOPE 2'h0
`define RCF_FLD_OPDLY 2'h1
`define RCF_FLD_MINDLY 2'h2

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define RCF_CTRL_GRP_LSB 0
`define RCF_CTRL_SRC_LSB 2
`define RCF_CTRL_SON_BIT 4
`define RCF_CTRL_SOFF_BIT 5
`define RCF_CTRL_TON_BIT 6
`define RCF_CTRL_TOFF_BIT 7
`define RCF_CTRL_RST 8'hF0

////////////////////////////////////////////////////////////////////////////////
// Setting units: slope in 0.01 Hz/s, delays in protection ticks
`define RCF_SLOPE_MIN 16'h0014
`define RCF_SLOPE_MAX 16'h03E8
`define RCF_SLOPE_RST 16'h01F4
`define RCF_DLY_MIN 16'h000E
`define RCF_DLY_MAX 16'h03E8
`define RCF_DLY_RST 16'h0032
`define RCF_SLOW_SLOPE 16'h0046
`define RCF_SLOW_FLOOR_TICKS 30
`define RCF_PCT_FULL 8'h64

////////////////////////////////////////////////////////////////////////////////
// Timing, in milliseconds and in protection ticks
`define RCF_TICK_MS 10
`define RCF_PICKUP_MS 80
`define RCF_START_MS 60
`define RCF_STABLE_MS 80
`define RCF_PICKUP_TICKS (`RCF_PICKUP_MS / `RCF_TICK_MS)
`define RCF_START_TICKS (`RCF_START_MS / `RCF_TICK_MS)
`define RCF_STABLE_TICKS (`RCF_STABLE_MS / `RCF_TICK_MS)

`endif

// >>> rtl/rcf_pkg.sv
// Types of the frequency slope protection stage.
// Assumes the constants header is included by each design file that needs it.
package rcf_pkg;

  // Stage condition
  typedef enum logic [1:0] {
    RCF_IDLE,
    RCF_PICKED,
    RCF_TRIPPED
  } rcf_state_t;

  // Source of the active setting group
  typedef enum logic [1:0] {
    RCF_SRC_MANUAL,
    RCF_SRC_DI,
    RCF_SRC_VI
  } rcf_src_t;

endpackage

// >>> rtl/rcf_setmem.sv
// Setting group store: groups of four 16-bit words, one write and two read ports.
// Assumes one synchronous clock; read data appear one edge after the address.
`include "rcf_params.svh"

module rcf_setmem #(
  parameter int W = 16,
  parameter int GRPS = 4,
  parameter logic [W-1:0] RST_SLOPE = `RCF_SLOPE_RST,
  parameter logic [W-1:0] RST_DLY = `RCF_DLY_RST
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [$clog2(GRPS*4)-1:0] wr_addr_in,
  input wire logic [W-1:0] wr_data_in,
  // Read port A
  input wire logic [$clog2(GRPS*4)-1:0] rd_a_addr_in,
  output logic [W-1:0] rd_a_data_out,
  // Read port B
  input wire logic [$clog2(GRPS*4)-1:0] rd_b_addr_in,
  output logic [W-1:0] rd_b_data_out
);

  localparam int N = GRPS * 4;
  localparam int AW = $clog2(N);

  logic [W-1:0] mem_r [N];

  ////////////////////////////////////////////////////////////////////////////////
  // One word per entry, slope default in field 0, delay default elsewhere
  for (genvar i = 0; i < N; i++) begin : g_ent
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        mem_r[i] <= ((i % 4) == 0) ? RST_SLOPE : RST_DLY;
      end else if (wr_en_in && (wr_addr_in == AW'(i))) begin
        mem_r[i] <= wr_data_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered reads; port A resets to the slope default its first reader expects
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rd_a_data_out <= RST_SLOPE;
      rd_b_data_out <= '0;
    end else begin
      rd_a_data_out <= mem_r[rd_a_addr_in];
      rd_b_data_out <= mem_r[rd_b_addr_in];
    end
  end

endmodule

// >>> dv/rcf_meas_src.sv
// Measurement path model: periodic tick pulse with slope sample.
// Assumes the bench picks the slope value and shares the stage clock.
module rcf_meas_src #(
  parameter int PER = 40
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Slope to present
  input wire logic signed [15:0] val_in,
  // Measurement outputs
  output logic tick_out = 1'b0,
  output logic signed [15:0] slope_out = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // One tick per PER cycles; slope is only valid on tick cycles
  always_ff @(posedge mclk_in) begin
    cnt <= (srst_in || cnt == PER - 1) ? 0 : cnt + 1;
    tick_out <= !srst_in && cnt == PER - 1;
    slope_out <= (cnt == PER - 1) ? val_in : ~val_in;
  end
endmodule

// >>> dv/rcf_stage_chk.sv
// Checker of stage outputs against tick and event relations.
// Assumes it is bound to the stage and sees only its ports.
module rcf_stage_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Watched ports
  input wire logic tick_in,
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic start_on_evt_out,
  input wire logic start_off_evt_out,
  input wire logic trip_on_evt_out,
  input wire logic trip_off_evt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////////////////////
  // Events follow output edges
  a_son_edge: assert property (start_on_evt_out |-> $rose(start_out))
    else $error("start-on event without start edge");
  a_soff_edge: assert property (start_off_evt_out |-> $fell(start_out))
    else $error("start-off event without start drop");
  a_ton_edge: assert property (trip_on_evt_out |-> $rose(trip_out))
    else $error("trip-on event without trip edge");
  a_toff_edge: assert property (trip_off_evt_out |-> $fell(trip_out))
    else $error("trip-off event without trip drop");
  a_evt_pulse: assert property (trip_on_evt_out |=> !trip_on_evt_out)
    else $error("trip-on event longer than one cycle");
  // Output timing and consistency
  a_tick_moves: assert property (($changed(start_out) || $changed(trip_out)) |-> $past(tick_in))
    else $error("output changed off a tick");
  a_trip_start: assert property (trip_out |-> start_out)
    else $error("trip without start");
  a_drop_both: assert property ($fell(start_out) |-> !trip_out)
    else $error("trip held after release");
endmodule
bind rcf_stage rcf_stage_chk chk_u (.mclk_in(mclk_in), .srst_in(srst_in), .tick_in(tick_in),
  .start_out(start_out), .trip_out(trip_out), .start_on_evt_out(start_on_evt_out),
  .start_off_evt_out(start_off_evt_out), .trip_on_evt_out(trip_on_evt_out),
  .trip_off_evt_out(trip_off_evt_out));

// >>> dv/rcf_stage_tb.sv
// Bench of the slope stage: register access and fault runs over ticks.
// Assumes the measurement model ticks every 40 cycles.
module rcf_stage_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic tick_in, start_out, trip_out, son, sof, ton, tof, awrd, wrd, bv, arrd, rv;
  logic signed [15:0] slope_in;
  logic signed [15:0] val = 16'h0000;
  logic [1:0] gdi = 2'h1, gvi = 2'h2, br, rr;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdt;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  int fail_count = 0, samples_checked = 0, tk = 0, evn = 0;
  // Clock, tick count and event count
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (tick_in === 1'b1) tk <= tk + 1;
  always @(posedge mclk_in) evn <= evn + int'(son) + int'(sof) + int'(ton) + int'(tof);
  rcf_meas_src #(.PER(40)) mdl_u (.mclk_in(mclk_in), .srst_in(srst_in), .val_in(val),
    .tick_out(tick_in), .slope_out(slope_in));
  rcf_stage dut_u (.mclk_in(mclk_in), .srst_in(srst_in), .tick_in(tick_in), .slope_in(slope_in),
    .grp_di_in(gdi), .grp_vi_in(gvi), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awrd), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arrd), .s_axi_rdata_out(rdt), .s_axi_rresp_out(rr),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .start_out(start_out), .trip_out(trip_out),
    .start_on_evt_out(son), .start_off_evt_out(sof), .trip_on_evt_out(ton),
    .trip_off_evt_out(tof));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task lim(input int i, input int n);
    if (i >= n) begin
      fail_count++;
      close_out();
    end
  endtask
  // Register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge mclk_in);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge mclk_in);
      if (awrd === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    bre <= 1'b0;
    lim(i, 99);
    chk(32'(br), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge mclk_in);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge mclk_in);
      if (arrd === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    rre <= 1'b0;
    lim(i, 99);
    chk(rdt, d);
    chk(32'(rr), 32'(r));
  endtask
  // Fault run: tick index of start and trip, release, event count
  task automatic run(input logic signed [15:0] v, input int es, input int et, input int ee);
    int b, st, tt, e0, i;
    st = 0;
    tt = 0;
    e0 = evn;
    for (i = 0; i < 99 && tick_in !== 1'b1; i++) @(negedge mclk_in);
    lim(i, 99);
    b = tk + 1;
    @(posedge mclk_in) val <= v;
    for (i = 0; i < 9999 && tt == 0; i++) begin
      @(negedge mclk_in);
      if (start_out === 1'b1 && st == 0) st = tk - b;
      if (trip_out === 1'b1) tt = tk - b;
    end
    lim(i, 9999);
    @(posedge mclk_in) val <= 16'h0000;
    for (i = 0; i < 9999 && start_out !== 1'b0; i++) @(negedge mclk_in);
    lim(i, 9999);
    // Let the off-event pulses of the release cycle reach the event count
    @(negedge mclk_in);
    chk(st, es);
    chk(tt, et);
    chk(evn - e0, ee);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_defaults;
    rd(8'h00, 32'hF0, 2'h0);
    rd(8'h40, 32'h1F4, 2'h0);
    rd(8'h78, 32'h32, 2'h0);
    rd(8'h4C, 32'h0, 2'h3);
  endtask
  task t_ranges;
    wr(8'h40, 32'h13, 2'h2);
    wr(8'h40, 32'h3E9, 2'h2);
    wr(8'h54, 32'hD, 2'h2);
    wr(8'h54, 32'hE, 2'h0);
    wr(8'h10, 32'h0, 2'h2);
    rd(8'h40, 32'h1F4, 2'h0);
  endtask
  task automatic t_groups;
    logic [7:0] cv [3] = '{8'hF3, 8'hF4, 8'hF8};
    logic [7:0] sv [3] = '{8'h30, 8'h10, 8'h20};
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, {24'h0, cv[k]}, 2'h0);
      repeat (4) @(posedge mclk_in);
      rd(8'h04, {24'h0, sv[k]}, 2'h0);
    end
    wr(8'h00, 32'hF0, 2'h0);
  endtask
  task t_definite;
    run(16'hFDA8, 14, 58, 4);
    rd(8'h10, 32'h258, 2'h0);
    rd(8'h14, 32'h64, 2'h0);
  endtask
  task t_inverse;
    wr(8'h48, 32'hE, 2'h0);
    run(16'h03E8, 14, 33, 4);
    run(16'h1388, 14, 22, 4);
  endtask
  task t_floor;
    wr(8'h00, 32'h00, 2'h0);
    wr(8'h40, 32'h32, 2'h0);
    run(16'h1388, 14, 38, 0);
    rd(8'h10, 32'h1388, 2'h0);
    rd(8'h08, 32'h4, 2'h0);
    rd(8'h0C, 32'h4, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_defaults();
    t_ranges();
    t_groups();
    t_definite();
    t_inverse();
    t_floor();
    close_out();
  end
endmodule
